/* src/hot_plug_slot_power_sequencer.v */
// Hot-plug slot power sequencer with APB register file, one FSM per slot
//
// Summary of operation
// - Presence bits and power control bit reset to one
// - Slot implemented reads one; indicators idle high
// - Latch low at reset exit clears control
// - Control still set keeps slot disabled
// - Power-up waits for reset and config load
// - First step: indicator and power enable low
// - Clock enable after programmed power-valid delay
// - Slot reset released after reset-release delay
// - Runtime latch closure starts power-up
// - Latch or button events raise enabled interrupt
// - Latch and button debounced for 10 ms
// - No controller: reset high while control clear, indicator low
// - Power indicator never lit without present bit
// - Defaults without latch keep slot in reset
// - No controller: control bit drives slot reset directly
// - Control set holds outputs at disabled levels
// - Power down by control bit or latch open
// - Down order: reset, clock, power, 100 us
// - Power-valid codes 16, 32, 64, 128 ms
// - Reset-release bit: 0 20 ms, 1 100 ms
// - Disabled slot: enables high, reset low
`include "hp_seq_map.vh"
`default_nettype none

module hot_plug_slot_power_sequencer #(
  parameter integer NUM_SLOTS = 3,
  parameter [15:0] CYCLES_PER_US = `US_CYCLES,
  parameter [15:0] US_PER_MS = `MS_US
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire upstream_reset_n,
  input wire config_load_done,
  input wire [NUM_SLOTS-1:0] retention_latch_n,
  input wire [NUM_SLOTS-1:0] attention_button_n,
  output wire [NUM_SLOTS-1:0] slot_power_enable_n,
  output wire [NUM_SLOTS-1:0] refclk_enable_n,
  output wire [NUM_SLOTS-1:0] slot_reset_n,
  output wire [NUM_SLOTS-1:0] power_indicator_n,
  output wire [NUM_SLOTS-1:0] attention_indicator_n,
  output wire hotplug_event
);

  // Slot sequencer states
  localparam [2:0] S_OFF = 3'h0; // Disabled levels
  localparam [2:0] S_PV = 3'h1; // Power on, waiting for valid
  localparam [2:0] S_RR = 3'h2; // Clock on, waiting to release reset
  localparam [2:0] S_ON = 3'h3; // Fully powered
  localparam [2:0] S_DNC = 3'h4; // Reset asserted, clock still on
  localparam [2:0] S_DNP = 3'h5; // Clock off, power still on
  localparam [2:0] S_DIRECT = 3'h6; // No power controller, reset follows bit

  localparam [7:0] STEP_US = `PWR_DOWN_STEP_US;

  // ==============================
  // Upstream reset synchroniser
  // ==============================
  reg up_meta_q; // First stage only
  reg up_q; // Synchronised upstream reset released
  reg up_dly_q; // Previous up_q, for the release edge
  wire up_rise; // One-cycle pulse at reset exit
  wire run; // Upstream released and load finished

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_meta_q <= 1'b0;
      up_q <= 1'b0;
      up_dly_q <= 1'b0;
    end else begin
      up_meta_q <= upstream_reset_n;
      up_q <= up_meta_q;
      up_dly_q <= up_q;
    end
  end

  assign up_rise = up_q & ~up_dly_q;
  assign run = up_q & config_load_done;

  // ==============================
  // Microsecond and millisecond tick generator
  // ==============================
  // Shared by all slots; each slot keeps its own counter.
  reg [15:0] us_div_q; // Cycles within one microsecond
  reg [15:0] ms_div_q; // Microseconds within one millisecond
  reg us_tick_q; // One-cycle pulse each microsecond
  reg ms_tick_q; // One-cycle pulse each millisecond

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_div_q <= 16'h0000;
      ms_div_q <= 16'h0000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
      if (us_div_q == CYCLES_PER_US - 16'h0001) begin
        us_div_q <= 16'h0000;
        us_tick_q <= 1'b1;
        if (ms_div_q == US_PER_MS - 16'h0001) begin
          ms_div_q <= 16'h0000;
          ms_tick_q <= 1'b1;
        end else begin
          ms_div_q <= ms_div_q + 16'h0001;
        end
      end else begin
        us_div_q <= us_div_q + 16'h0001;
      end
    end
  end

  // ==============================
  // APB decode
  // ==============================
  wire setup = psel & ~penable; // First cycle of a transfer
  wire access = psel & penable; // Completing cycle
  wire wr_en = access & pwrite; // Write takes effect here
  wire glob_hit = (paddr == `OFF_GLOBAL);
  wire slot_hit = (paddr[1:0] == 2'b00) && (paddr[7:4] < NUM_SLOTS);
  wire mapped = glob_hit | slot_hit;
  wire [NUM_SLOTS*32-1:0] slot_rd; // Read words, one per slot
  wire [NUM_SLOTS-1:0] slot_irq; // Enabled events per slot
  reg [31:0] rd_word; // Selected read word

  // Zero wait states
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign hotplug_event = |slot_irq;

  // Read mux
  always @* begin : rd_mux
    integer i;
    i = 0;
    rd_word = 32'h0000_0000;
    if (glob_hit) begin
      rd_word[`GL_SLOT_IMPL] = 1'b1;
      rd_word[`GL_RUN] = run;
      rd_word[`GL_UPSTREAM] = up_q;
    end else if (slot_hit) begin
      for (i = 0; i < NUM_SLOTS; i = i + 1) begin
        if (paddr[7:4] == i[3:0]) begin
          rd_word = slot_rd[i*32 +: 32];
        end
      end
    end
  end

  // Read data captured in setup, from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // ==============================
  // Per-slot register block and sequencer
  // ==============================
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : slot
      localparam [3:0] IDX = g;
      reg [4:1] cap_q; // Presence capabilities
      reg [10:0] ctl_q; // Event enables and power control bit
      reg [6:0] cfg_q; // Delay selectors
      reg [1:0] evt_q; // Sticky button and latch events
      reg [2:0] state_q; // Sequencer state
      reg [7:0] cnt_q; // Remaining ticks in this step
      reg pwr_n_q; // Slot power enable, active low
      reg clk_n_q; // Reference clock enable, active low
      reg rst_n_q; // Slot reset, active low
      reg ind_n_q; // Power indicator, active low
      reg atn_n_q; // Attention indicator, active low
      reg [7:0] pv_ms; // Decoded power-valid delay
      wire [7:0] rr_ms; // Decoded reset-release delay
      wire latch_sync, latch_db, latch_chg;
      wire btn_db, btn_chg;
      wire hit = slot_hit && (paddr[7:4] == IDX);
      wire [1:0] ridx = paddr[3:2];
      wire pcp = cap_q[`CAP_PCP];
      wire lsp = cap_q[`CAP_LSP];
      wire pip = cap_q[`CAP_PIP];
      wire pcc = ctl_q[`CTL_PCC];
      wire latch_ok = ~lsp | ~latch_db; // Latch closed or not sensed
      wire want_up = run & pcp & ~pcc & latch_ok;
      wire want_dn = ~pcp | pcc | (lsp & latch_db);
      wire ind_on = (state_q == S_PV) | (state_q == S_RR) |
                    (state_q == S_ON) | (state_q == S_DIRECT);
      wire [1:0] evt_set = {latch_chg, btn_chg & ~btn_db};
      wire [1:0] evt_clr = (wr_en && hit && ridx == `OFF_STATUS) ?
                           pwdata[1:0] : 2'b00;

      // Latch input, captured outright at reset exit.
      debounce_filter u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick_q),
        .load(up_rise),
        .pin_n(retention_latch_n[g]),
        .sync_level(latch_sync),
        .stable_q(latch_db),
        .change_q(latch_chg)
      );

      // Attention button input
      debounce_filter u_button (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick_q),
        .load(1'b0),
        .pin_n(attention_button_n[g]),
        .sync_level(),
        .stable_q(btn_db),
        .change_q(btn_chg)
      );

      // Delay decode
      always @* begin
        case (cfg_q[`CFG_PV_HI:`CFG_PV_LO])
          2'b00: pv_ms = `PV_BASE_MS;
          2'b01: pv_ms = `PV_BASE_MS << 1;
          2'b10: pv_ms = `PV_BASE_MS << 2;
          default: pv_ms = `PV_BASE_MS << 3;
        endcase
      end
      assign rr_ms = cfg_q[`CFG_RR] ? `RR_LONG_MS : `RR_SHORT_MS;

      // Register writes; hardware sampling at reset exit wins last
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_q <= `CAP_RESET;
          ctl_q <= `CTRL_RESET;
          cfg_q <= `CFG_RESET;
        end else begin
          if (wr_en && hit && ridx == `OFF_CAP) begin
            cap_q <= pwdata[4:1];
          end
          if (wr_en && hit && ridx == `OFF_CTRL) begin
            ctl_q <= pwdata[10:0] & `CTRL_WMASK;
          end
          if (wr_en && hit && ridx == `OFF_CFG) begin
            cfg_q <= pwdata[6:0] & `CFG_WMASK;
          end
          if (up_rise && lsp && !latch_sync) begin
            ctl_q[`CTL_PCC] <= 1'b0;
          end
        end
      end

      // Sticky events: a new event beats a same-cycle clear
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          evt_q <= 2'b00;
        end else begin
          evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
      end

      assign slot_irq[g] = ctl_q[`CTL_HPIE] &
        ((evt_q[`ST_BTN_EVT] & ctl_q[`CTL_BTN_EN]) |
         (evt_q[`ST_LATCH_EVT] & ctl_q[`CTL_LATCH_EN]));

      // Sequencer: steps advance after N+1 ticks so no step is short
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state_q <= S_OFF;
          cnt_q <= 8'h00;
          pwr_n_q <= 1'b1;
          clk_n_q <= 1'b1;
          rst_n_q <= 1'b0;
        end else if (!up_q) begin
          // Upstream reset: disabled levels
          state_q <= S_OFF;
          cnt_q <= 8'h00;
          pwr_n_q <= 1'b1;
          clk_n_q <= 1'b1;
          rst_n_q <= 1'b0;
        end else begin
          case (state_q)
            S_OFF: begin
              // Stay disabled.
              if (run && !pcp) begin
                state_q <= S_DIRECT;
              end else if (want_up) begin
                state_q <= S_PV;
                cnt_q <= pv_ms;
                pwr_n_q <= 1'b0;
              end
            end
            S_PV: begin
              if (want_dn) begin
                state_q <= S_DNC;
                cnt_q <= STEP_US;
                rst_n_q <= 1'b0;
              end else if (ms_tick_q) begin
                if (cnt_q == 8'h00) begin
                  state_q <= S_RR;
                  cnt_q <= rr_ms;
                  clk_n_q <= 1'b0;
                end else begin
                  cnt_q <= cnt_q - 8'h01;
                end
              end
            end
            S_RR: begin
              if (want_dn) begin
                state_q <= S_DNC;
                cnt_q <= STEP_US;
                rst_n_q <= 1'b0;
              end else if (ms_tick_q) begin
                if (cnt_q == 8'h00) begin
                  state_q <= S_ON;
                  rst_n_q <= 1'b1;
                end else begin
                  cnt_q <= cnt_q - 8'h01;
                end
              end
            end
            S_ON: begin
              if (want_dn) begin
                state_q <= S_DNC;
                cnt_q <= STEP_US;
                rst_n_q <= 1'b0;
              end
            end
            S_DNC: begin
              if (us_tick_q) begin
                if (cnt_q == 8'h00) begin
                  state_q <= S_DNP;
                  cnt_q <= STEP_US;
                  clk_n_q <= 1'b1;
                end else begin
                  cnt_q <= cnt_q - 8'h01;
                end
              end
            end
            S_DNP: begin
              if (us_tick_q) begin
                if (cnt_q == 8'h00) begin
                  state_q <= S_OFF;
                  pwr_n_q <= 1'b1;
                end else begin
                  cnt_q <= cnt_q - 8'h01;
                end
              end
            end
            S_DIRECT: begin
              // Enables unused here
              pwr_n_q <= 1'b1;
              clk_n_q <= 1'b1;
              if (pcp) begin
                state_q <= S_OFF;
                rst_n_q <= 1'b0;
              end else begin
                rst_n_q <= ~pcc;
              end
            end
            default: begin
              state_q <= S_OFF;
              pwr_n_q <= 1'b1;
              clk_n_q <= 1'b1;
              rst_n_q <= 1'b0;
            end
          endcase
        end
      end

      // Indicators
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ind_n_q <= 1'b1;
          atn_n_q <= 1'b1;
        end else begin
          ind_n_q <= ~(ind_on & pip & up_q);
          atn_n_q <= 1'b1;
        end
      end

      // Status and read words
      assign slot_rd[g*32 +: 32] =
        (ridx == `OFF_CAP) ? {27'h0, cap_q, 1'b0} :
        (ridx == `OFF_CTRL) ? {21'h0, ctl_q} :
        (ridx == `OFF_CFG) ? {25'h0, cfg_q} :
        {25'h0, state_q, ~ind_n_q, latch_db, evt_q};

      assign slot_power_enable_n[g] = pwr_n_q;
      assign refclk_enable_n[g] = clk_n_q;
      assign slot_reset_n[g] = rst_n_q;
      assign power_indicator_n[g] = ind_n_q;
      assign attention_indicator_n[g] = atn_n_q;
    end
  endgenerate

endmodule // hot_plug_slot_power_sequencer

`default_nettype wire

/* src/hp_seq_map.vh */
// Register map and timing for the slot sequencer
`ifndef HP_SEQ_MAP_VH
`define HP_SEQ_MAP_VH

// ==============================
// Clock and time base
// ==============================
`define CLK_FREQ_MHZ 200
`define TICK_US 1
`define US_CYCLES (`TICK_US * `CLK_FREQ_MHZ)
`define MS_US 1000

// ==============================
// Sequencing times
// ==============================
`define DEBOUNCE_MS 10
`define PWR_DOWN_STEP_US 8'h64
`define PV_BASE_MS 8'h10
`define RR_SHORT_MS 8'h14
`define RR_LONG_MS 8'h64

// ==============================
// Register offsets
// ==============================
`define SLOT_STRIDE 8'h10
`define OFF_CAP 2'h0
`define OFF_CTRL 2'h1
`define OFF_STATUS 2'h2
`define OFF_CFG 2'h3
`define OFF_GLOBAL 8'h80

// ==============================
// Field positions
// ==============================
`define CAP_PCP 1
`define CAP_LSP 2
`define CAP_AIP 3
`define CAP_PIP 4
`define CTL_BTN_EN 0
`define CTL_LATCH_EN 2
`define CTL_HPIE 5
`define CTL_PCC 10
`define CFG_PV_LO 3
`define CFG_PV_HI 4
`define CFG_RR 6
`define ST_BTN_EVT 0
`define ST_LATCH_EVT 1
`define ST_LATCH 2
`define ST_IND 3
`define ST_STATE_LO 4
`define GL_RUN 0
`define GL_UPSTREAM 1
`define GL_SLOT_IMPL 24

// ==============================
// Reset values and write masks
// ==============================
`define CAP_RESET 4'hF
`define CTRL_RESET 11'h400
`define CTRL_WMASK 11'h425
`define CFG_RESET 7'h40
`define CFG_WMASK 7'h58

`endif

/* src/debounce_filter.v */
// Two-stage synchroniser and millisecond debounce for one active-low input pin
`include "hp_seq_map.vh"
`default_nettype none

module debounce_filter #(
  parameter [7:0] STABLE_MS = `DEBOUNCE_MS
) (
  input wire pclk,
  input wire presetn,
  input wire ms_tick,
  input wire load,
  input wire pin_n,
  output wire sync_level,
  output reg stable_q,
  output reg change_q
);

  reg meta_q; // First stage, read only by sync_q
  reg sync_q; // Second stage, safe to use
  reg [7:0] cnt_q; // Milliseconds of disagreement seen

  // ==============================
  // Synchroniser
  // ==============================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_n;
      sync_q <= meta_q;
    end
  end

  assign sync_level = sync_q;

  // ==============================
  // Stability filter
  // ==============================
  // New level after STABLE_MS + 1 ticks, so the wait is never short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 1'b1;
      cnt_q <= 8'h00;
      change_q <= 1'b0;
    end else begin
      change_q <= 1'b0;
      if (load) begin
        // Immediate capture, no event reported
        stable_q <= sync_q;
        cnt_q <= 8'h00;
      end else if (sync_q == stable_q) begin
        cnt_q <= 8'h00; // Bounce restarts the wait
      end else if (ms_tick) begin
        if (cnt_q == STABLE_MS) begin
          stable_q <= sync_q;
          change_q <= 1'b1;
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // debounce_filter

`default_nettype wire

/* test/hp_seq_sva.sv */
// Checker on sequencer ports, slot 0 timing
`default_nettype none
module hp_seq_sva #(parameter integer NUM_SLOTS = 3) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic upstream_reset_n,
  input wire logic [NUM_SLOTS-1:0] slot_power_enable_n,
  input wire logic [NUM_SLOTS-1:0] refclk_enable_n,
  input wire logic [NUM_SLOTS-1:0] slot_reset_n,
  input wire logic [NUM_SLOTS-1:0] power_indicator_n,
  input wire logic [NUM_SLOTS-1:0] attention_indicator_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Cycles since slot 0 enables last moved
  // ==========================================
  logic [2:0] prev_q; // Last seen power, clock, reset
  logic [12:0] cnt_q; // Saturates, never wraps
  wire [2:0] now_w = {slot_power_enable_n[0], refclk_enable_n[0], slot_reset_n[0]};
  // Restart on any enable change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 3'h6;
      cnt_q <= 13'h0;
    end else begin
      prev_q <= now_w;
      cnt_q <= (now_w != prev_q) ? 13'h0 : cnt_q + {12'h0, ~&cnt_q};
    end
  end
  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_up_order: assert property (
    $fell(slot_power_enable_n[0]) |-> refclk_enable_n[0] && !slot_reset_n[0])
    else $error("power enabled out of order");
  a_ind_follows: assert property (
    $fell(slot_power_enable_n[0]) |=> !power_indicator_n[0])
    else $error("indicator not lit");
  a_pv_min: assert property (
    $fell(refclk_enable_n[0]) |-> cnt_q >= 13'h27E)
    else $error("clock early");
  a_rr_min: assert property (
    $rose(slot_reset_n[0]) && !slot_power_enable_n[0] |-> cnt_q >= 13'h31E)
    else $error("reset early");
  a_clk_off_time: assert property (
    $rose(refclk_enable_n[0]) && upstream_reset_n |-> cnt_q >= 13'h18C)
    else $error("clock removed too soon");
  a_pwr_off_time: assert property (
    $rose(slot_power_enable_n[0]) && upstream_reset_n |-> cnt_q >= 13'h18C)
    else $error("power removed too soon");
  a_dn_ind: assert property (
    $fell(slot_reset_n[0]) && !slot_power_enable_n[0] |-> ##[0:2] power_indicator_n[0])
    else $error("indicator lit during power down");
  a_force_off: assert property (
    !upstream_reset_n [*5] |-> &slot_power_enable_n && &refclk_enable_n && !(|slot_reset_n))
    else $error("slot not disabled");
  a_atn_off: assert property (&attention_indicator_n)
    else $error("attention indicator driven");
  a_unmapped: assert property (
    psel && penable && paddr == 8'(NUM_SLOTS * 16) |-> pslverr && pready)
    else $error("no error");
endmodule // hp_seq_sva
bind hot_plug_slot_power_sequencer hp_seq_sva #(.NUM_SLOTS(NUM_SLOTS)) chk_u (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .upstream_reset_n,
  .slot_power_enable_n, .refclk_enable_n, .slot_reset_n, .power_indicator_n,
  .attention_indicator_n);
`default_nettype wire

/* test/slot_partner.sv */
// Far-side model: retention latches, attention buttons and the cards
`default_nettype none
module slot_partner #(parameter integer N = 2) (
  input wire logic [N-1:0] latch_close,
  input wire logic [N-1:0] btn_press,
  input wire logic [N-1:0] slot_power_enable_n,
  input wire logic [N-1:0] refclk_enable_n,
  input wire logic [N-1:0] slot_reset_n,
  output logic [N-1:0] retention_latch_n,
  output logic [N-1:0] attention_button_n,
  output logic [N-1:0] card_live
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Mechanical contacts, low while closed
  // ==========================================
  // Latch pin low while latch_close is set
  assign retention_latch_n = ~latch_close;
  assign attention_button_n = ~btn_press;
  // Live with power, clock and reset released
  assign card_live = ~slot_power_enable_n & ~refclk_enable_n & slot_reset_n;
endmodule // slot_partner
`default_nettype wire

/* test/test_hot_plug_slot_power_sequencer.sv */
// Self-checking bench for the hot-plug slot power sequencer
`default_nettype none
module test_hot_plug_slot_power_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic upstream_reset_n, config_load_done, hotplug_event;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [N-1:0] retention_latch_n, attention_button_n, slot_power_enable_n;
  logic [N-1:0] refclk_enable_n, slot_reset_n, power_indicator_n, attention_indicator_n;
  logic [N-1:0] close, press, live; // Model commands
  int error_cnt = 0;
  int num_checks = 0;
  int n; // Cycles counted by the last wait
  // ==========================================
  // Design, far side and clock
  // ==========================================
  // Short ticks: 1 ms is 40 cycles
  hot_plug_slot_power_sequencer #(.NUM_SLOTS(N), .CYCLES_PER_US(16'h4),
    .US_PER_MS(16'hA)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .upstream_reset_n, .config_load_done,
    .retention_latch_n, .attention_button_n, .slot_power_enable_n, .refclk_enable_n,
    .slot_reset_n, .power_indicator_n, .attention_indicator_n, .hotplug_event);
  slot_partner #(.N(N)) far_u (.latch_close(close), .btn_press(press),
    .slot_power_enable_n, .refclk_enable_n, .slot_reset_n, .retention_latch_n,
    .attention_button_n, .card_live(live));
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic rng(input int lo, hi, input string m);
    chk(32'(n >= lo && n <= hi), 32'h1, m);
  endtask
  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic sig(input int k, s);
    case (k)
      0: return slot_power_enable_n[s];
      1: return refclk_enable_n[s];
      3: return power_indicator_n[s];
      default: return slot_reset_n[s];
    endcase
  endfunction
  // Bounded wait for a level
  task automatic wt(input int k, s, input logic v, input int lim);
    n = 0;
    while (sig(k, s) !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic up_seq(input int s, pv, rr);
    wt(0, s, 1'h0, 200);
    chk(refclk_enable_n[s], 1'h1, "clock before power");
    @(negedge pclk);
    chk(power_indicator_n[s], 1'h0, "indicator");
    wt(1, s, 1'h0, pv * 40 + 100);
    rng(pv * 40 - 2, pv * 40 + 44, "pv delay");
    wt(2, s, 1'h1, rr * 40 + 100);
    rng(rr * 40 - 2, rr * 40 + 44, "rr delay");
  endtask
  task automatic dn_seq(input int s);
    wt(2, s, 1'h0, 500);
    wt(1, s, 1'h1, 500);
    rng(396, 408, "clock off");
    chk(slot_power_enable_n[s], 1'h0, "power early off");
    wt(0, s, 1'h1, 500);
    rng(396, 408, "power off");
    chk(power_indicator_n[s], 1'h1, "indicator off");
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset();
    chk({slot_power_enable_n, refclk_enable_n, slot_reset_n}, 6'h3C, "idle");
    chk({power_indicator_n, attention_indicator_n}, 4'hF, "leds");
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1E, "caps");
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h400, "control");
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h40, "timing cfg");
    apb(1'h0, 8'h80, 32'h0);
    chk(rd[24], 1'h1, "slot implemented");
    apb(1'h1, 8'h20, 32'hFFFF);
    chk(er, 1'h1, "unmapped error");
    $display("reset test done");
  endtask
  task automatic t_start();
    @(posedge pclk);
    upstream_reset_n <= 1'h1;
    repeat (60) @(negedge pclk);
    chk(slot_power_enable_n[0], 1'h1, "up before load");
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h0, "pcc cleared");
    apb(1'h0, 8'h14, 32'h0);
    chk(rd, 32'h400, "pcc kept");
    config_load_done <= 1'h1;
    up_seq(0, 16, 100);
    chk(live[0], 1'h1, "card live");
    chk({slot_power_enable_n[1], refclk_enable_n[1], slot_reset_n[1],
      power_indicator_n[1]}, 4'hD, "slot 1 disabled");
    $display("startup test done");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, 8'h04, 32'h400);
      dn_seq(0);
      apb(1'h1, 8'h0C, 32'((c & 1) << 6 | c << 3));
      apb(1'h1, 8'h04, 32'h0);
      up_seq(0, 16 << c, (c & 1) ? 100 : 20);
    end
    $display("delay code test done");
  endtask
  task automatic t_abort();
    apb(1'h1, 8'h04, 32'h400);
    dn_seq(0);
    apb(1'h1, 8'h04, 32'h0);
    wt(0, 0, 1'h0, 200);
    repeat (100) @(negedge pclk);
    apb(1'h1, 8'h04, 32'h400);
    wt(0, 0, 1'h1, 1000);
    rng(700, 830, "abort off");
    chk({refclk_enable_n[0], slot_reset_n[0]}, 2'h2, "abort order");
    $display("abort test done");
  endtask
  task automatic t_latch();
    apb(1'h1, 8'h14, 32'h25);
    close[1] <= 1'h1;
    repeat (200) @(posedge pclk);
    close[1] <= 1'h0;
    repeat (600) @(negedge pclk);
    chk({slot_power_enable_n[1], hotplug_event}, 2'h2, "glitch ignored");
    @(posedge pclk);
    close[1] <= 1'h1;
    wt(0, 1, 1'h0, 600);
    rng(398, 455, "latch debounce");
    apb(1'h0, 8'h18, 32'h0);
    chk(rd[1:0], 2'h2, "latch event");
    chk(hotplug_event, 1'h1, "event");
    apb(1'h1, 8'h18, 32'h2);
    @(negedge pclk);
    chk(hotplug_event, 1'h0, "event cleared");
    press[1] <= 1'h1;
    repeat (500) @(posedge pclk);
    press[1] <= 1'h0;
    repeat (500) @(negedge pclk);
    apb(1'h0, 8'h18, 32'h0);
    chk({rd[0], hotplug_event}, 2'h3, "button event");
    apb(1'h1, 8'h18, 32'h3);
    close[1] <= 1'h0;
    wt(3, 1, 1'h1, 600);
    rng(398, 460, "latch open");
    dn_seq(1);
    apb(1'h1, 8'h10, 32'h10);
    repeat (3) @(negedge pclk);
    chk({slot_reset_n[1], power_indicator_n[1], slot_power_enable_n[1]}, 3'h5, "direct");
    apb(1'h1, 8'h14, 32'h400);
    repeat (2) @(negedge pclk);
    chk(slot_reset_n[1], 1'h0, "reset follows pcc");
    $display("latch test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence and watchdog
  // ==========================================
  initial begin
    {presetn, psel, penable, pwrite, upstream_reset_n, config_load_done} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    close = 2'h1;
    press = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_start();
    t_codes();
    t_abort();
    t_latch();
    end_sim();
  end
  // Run takes ~33000 cycles
  initial begin
    #500us;
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule // test_hot_plug_slot_power_sequencer
`default_nettype wire
